// [core/bias_ctl_pkg.sv]
// Purpose: Shared constants for the DAC code update control block
// Assumes: Commands arrive already deframed from the serial interface
// Notes:   Command bytes other than the configuration ones are arbitrary
package bias_ctl_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CODE_W = 12;
	localparam int WORD_W = 16;
	localparam int CMD_W  = 8;
	localparam int CFG_W  = 12;

	// ----------------------------------------------------------------
	// Command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_HWCFG_WR  = 8'h38;
	localparam logic [7:0] CMD_HWCFG_RD  = 8'hB8;
	localparam logic [7:0] CMD_SWCFG_WR  = 8'h3A;
	localparam logic [7:0] CMD_SWCFG_RD  = 8'hBA;
	localparam logic [7:0] CMD_DACIN1_WR = 8'h40;
	localparam logic [7:0] CMD_DACIN2_WR = 8'h41;
	localparam logic [7:0] CMD_DACIO1_WR = 8'h42;
	localparam logic [7:0] CMD_DACIO2_WR = 8'h43;
	localparam logic [7:0] CMD_SETPT1_WR = 8'h44;
	localparam logic [7:0] CMD_SETPT2_WR = 8'h45;
	localparam logic [7:0] CMD_SWLOAD_WR = 8'h46;
	localparam logic [7:0] CMD_DACOUT1_RD = 8'hC2;
	localparam logic [7:0] CMD_DACOUT2_RD = 8'hC3;

	// ----------------------------------------------------------------
	// Software configuration fields, per channel base offset
	// ----------------------------------------------------------------
	localparam int SW_CH_STRIDE = 6;
	localparam int SW_KSRC_LSB  = 0;
	localparam int SW_TCTL_LSB  = 3;
	localparam int SW_LOAD_BIT  = 5;

	// Software load register transfer bits
	localparam int XFER_CH1_BIT = 0;
	localparam int XFER_CH2_BIT = 1;

	// ----------------------------------------------------------------
	// Hardware configuration fields
	// ----------------------------------------------------------------
	localparam int HW_CONV_REF_HI = 3;
	localparam int HW_CONV_REF_LO = 2;
	localparam int HW_DAC_REF_HI  = 1;
	localparam int HW_DAC_REF_LO  = 0;

	// ----------------------------------------------------------------
	// Reset values and special codes
	// ----------------------------------------------------------------
	localparam logic [11:0] CFG_RST   = 12'h000;
	localparam logic [11:0] CODE_RST  = 12'h000;
	localparam logic [11:0] CODE_MAX  = 12'hFFF;
	localparam logic [2:0]  KSRC_NONE = 3'h0;
	localparam logic [1:0]  TCTL_OFF  = 2'h0;

	// Fraction scaling: K is Q0.12, temperature Q1.11, product 2^-23
	localparam int FRAC_SHIFT = 23;
	localparam int K_TO_PROD  = 11;
	localparam int CALC_LAT   = 3;

endpackage

// [core/calc_if.sv]
// Purpose: Carrier between the register bank and the code calculator
// Assumes: One clock domain
// Notes:   ready is high while the calculator is idle
`timescale 1ns/1ps
interface calc_if;
	logic        start;
	logic        ch;
	logic [11:0] setpoint;
	logic [11:0] k_val;
	logic [11:0] t_val;
	logic        use_temp;
	logic        ready;
	logic        done;
	logic        done_ch;
	logic [11:0] code;

	modport bank (output start, ch, setpoint, k_val, t_val, use_temp,
		input ready, done, done_ch, code);
	modport calc (input start, ch, setpoint, k_val, t_val, use_temp,
		output ready, done, done_ch, code);
endinterface

// [core/code_calc.sv]
// Purpose: Computes a DAC code from a setpoint and two table factors
// Assumes: Table factors are already interpolated outside
// Notes:   Fixed latency of three cycles from start to done
`timescale 1ns/1ps
module code_calc (
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	calc_if.calc      cif
);
	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_MUL   = 2'b01,
		S_SCALE = 2'b10
	} calc_state_t;

	calc_state_t        state_r;
	logic signed [24:0] factor_r;
	logic        [11:0] set_r;
	logic               ch_r;
	logic               done_r;
	logic        [11:0] code_r;
	logic signed [37:0] scaled;
	logic signed [37:0] total;

	assign cif.ready   = (state_r == S_IDLE);
	assign cif.done    = done_r;
	assign cif.done_ch = ch_r;
	assign cif.code    = code_r;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_r <= S_IDLE;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (cif.start) begin
						state_r <= S_MUL;
					end
				end
				S_MUL:   state_r <= S_SCALE;
				S_SCALE: state_r <= S_IDLE;
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Factor stage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			factor_r <= 25'sh0;
			set_r    <= bias_ctl_pkg::CODE_RST;
			ch_r     <= 1'b0;
		end else if (state_r == S_IDLE && cif.start) begin
			set_r <= cif.setpoint;
			ch_r  <= cif.ch;
			// RULE15: fractional operands
			// RULE21: temperature term dropped
			if (cif.use_temp) begin
				factor_r <= 25'($signed({1'b0, cif.k_val}) * $signed(cif.t_val));
			end else begin
				factor_r <= 25'($signed({1'b0, cif.k_val}) <<< bias_ctl_pkg::K_TO_PROD);
			end
		end
	end

	// RULE14: setpoint times one plus factor
	always_comb begin
		scaled = 38'($signed({1'b0, set_r}) * factor_r) >>> bias_ctl_pkg::FRAC_SHIFT;
		total  = 38'($signed({1'b0, set_r})) + scaled;
	end

	// ----------------------------------------------------------------
	// Result stage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			code_r <= bias_ctl_pkg::CODE_RST;
			done_r <= 1'b0;
		end else begin
			done_r <= (state_r == S_SCALE);
			if (state_r == S_SCALE) begin
				// RULE22: clamp to code range
				if (total < 0) begin
					code_r <= bias_ctl_pkg::CODE_RST;
				end else if (total > 38'(bias_ctl_pkg::CODE_MAX)) begin
					code_r <= bias_ctl_pkg::CODE_MAX;
				end else begin
					code_r <= total[11:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	a_calc_latency: assert property (cif.start && cif.ready |-> ##3 cif.done) // RULE14
		else $error("calculation did not finish in three cycles");
	a_zero_k_pass: assert property (cif.start && cif.ready && cif.k_val == 12'h000 // RULE17
		|-> ##3 cif.code == $past(cif.setpoint, 3))
		else $error("zero K factor did not pass setpoint through");
	a_no_temp_gain: assert property (cif.start && cif.ready && !cif.use_temp // RULE21
		|-> ##3 cif.code >= $past(cif.setpoint, 3))
		else $error("temperature term used while disabled");
	c_calc_clamped: cover property (cif.done && cif.code == bias_ctl_pkg::CODE_MAX);
endmodule

// [core/dac_code_update_control.sv]
// Purpose: Configuration registers and DAC code loading for two channels
// Assumes: Command port is driven by the serial deframer on clk_in
// Notes:   Table values arrive interpolated from table logic outside
//
// Functional notes
// RULE1: Converter reference external when upper select bit is 0, else internal.
// RULE2: DAC reference external when upper select bit is 0, else internal.
// RULE3: Top four configuration bits are ignored and read back as zero.
// RULE4: Channel 2 direct load sends calculation to input and output.
// RULE5: Without direct load, channel 2 output waits for its transfer bit.
// RULE6: Busy pulses after a calculated code when direct load is set.
// RULE7: Bits 10 and 9 are the channel 2 temperature table control.
// RULE8: Bits 8 to 6 select the channel 2 K table source.
// RULE9: Bit 5 is the channel 1 direct load bit.
// RULE10: Bits 4 and 3 are the channel 1 temperature table control.
// RULE11: Bits 2 to 0 select the channel 1 K table source.
// RULE12: Input register write leaves output alone until transfer bit write.
// RULE13: Combined register write sets the output code at once.
// RULE14: Setpoint write starts calculation of setpoint times one plus K times T.
// RULE15: K factor is unsigned fraction, temperature factor signed fraction.
// RULE16: K index from setpoint, parameter or converter; temperature index internal or external.
// RULE17: K source 000 with temperature 00 or 01 passes setpoint only after a sample.
// RULE18: Host must enable converter channels and clock mode for automatic triggers.
// RULE19: Host writes software configuration with 3Ah and reads with BAh.
// RULE20: Converter reference select is bits 3:2, DAC select bits 1:0.
// RULE21: Temperature control 00 blocks temperature triggers and drops its term.
// RULE22: Calculated code is clamped to the unsigned 12-bit range.
`timescale 1ns/1ps
module dac_code_update_control (
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             cmd_valid_in,
	input  wire logic [7:0]       cmd_byte_in,
	input  wire logic [15:0]      cmd_data_in,
	input  wire logic [1:0][11:0] k_table_value_in,
	input  wire logic [1:0][11:0] temp_table_value_in,
	input  wire logic [1:0]       temp_sample_in,
	input  wire logic [1:0]       k_sample_in,
	output logic      [15:0]      rd_data_out,
	output logic                  rd_valid_out,
	output logic      [11:0]      ch1_dac_code_out,
	output logic      [11:0]      ch2_dac_code_out,
	output logic                  busy_out,
	output logic                  conv_vref_internal_out,
	output logic                  dac_vref_internal_out,
	output logic      [1:0][2:0]  k_source_sel_out,
	output logic      [1:0][1:0]  temp_table_ctl_out
);
	// ----------------------------------------------------------------
	// Field helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] ksrc_of(input logic [11:0] cfg, input logic ch);
		return ch ? cfg[bias_ctl_pkg::SW_CH_STRIDE + bias_ctl_pkg::SW_KSRC_LSB +: 3]
			: cfg[bias_ctl_pkg::SW_KSRC_LSB +: 3];
	endfunction

	function automatic logic [1:0] tctl_of(input logic [11:0] cfg, input logic ch);
		return ch ? cfg[bias_ctl_pkg::SW_CH_STRIDE + bias_ctl_pkg::SW_TCTL_LSB +: 2]
			: cfg[bias_ctl_pkg::SW_TCTL_LSB +: 2];
	endfunction

	function automatic logic load_of(input logic [11:0] cfg, input logic ch);
		return ch ? cfg[bias_ctl_pkg::SW_CH_STRIDE + bias_ctl_pkg::SW_LOAD_BIT]
			: cfg[bias_ctl_pkg::SW_LOAD_BIT];
	endfunction

	function automatic logic is_wr(input logic v, input logic [7:0] b, input logic [7:0] c);
		return v && (b == c);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [11:0]      swcfg_r;
	logic [11:0]      hwcfg_r;
	logic [1:0][11:0] dac_in_r;
	logic [1:0][11:0] dac_out_r;
	logic [1:0][11:0] setpt_r;
	logic [1:0]       pend_r;
	logic [1:0]       pend_nxt;
	logic [1:0]       seen_r;
	logic [1:0]       have_set_r;
	logic [1:0]       set_req;
	logic [1:0]       wr_in;
	logic [1:0]       wr_io;
	logic [1:0]       wr_set;
	logic [1:0]       xfer;
	logic             issue;
	logic             issue_ch;
	logic             busy_r;
	logic [15:0]      rd_data_r;
	logic             rd_valid_r;

	calc_if cif ();

	code_calc u_calc (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.cif        (cif)
	);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	always_comb begin
		wr_in  = {is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_DACIN2_WR),
			is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_DACIN1_WR)};
		wr_io  = {is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_DACIO2_WR),
			is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_DACIO1_WR)};
		wr_set = {is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SETPT2_WR),
			is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SETPT1_WR)};
		xfer   = is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SWLOAD_WR)
			? {cmd_data_in[bias_ctl_pkg::XFER_CH2_BIT], cmd_data_in[bias_ctl_pkg::XFER_CH1_BIT]}
			: 2'h0;
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			swcfg_r <= bias_ctl_pkg::CFG_RST;
			hwcfg_r <= bias_ctl_pkg::CFG_RST;
		end else begin
			// RULE19: configuration command bytes
			// RULE3: upper nibble dropped
			if (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SWCFG_WR)) begin
				swcfg_r <= cmd_data_in[bias_ctl_pkg::CFG_W-1:0];
			end
			if (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_HWCFG_WR)) begin
				hwcfg_r <= cmd_data_in[bias_ctl_pkg::CFG_W-1:0];
			end
		end
	end

	// RULE1: converter reference decode
	// RULE20: reference field positions
	assign conv_vref_internal_out = hwcfg_r[bias_ctl_pkg::HW_CONV_REF_HI];
	// RULE2: DAC reference decode
	assign dac_vref_internal_out  = hwcfg_r[bias_ctl_pkg::HW_DAC_REF_HI];

	// RULE7: channel field decode
	// RULE8: channel 2 K source
	// RULE10: channel 1 temperature control
	// RULE11: channel 1 K source
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			k_source_sel_out[c]   = ksrc_of(swcfg_r, 1'(c));
			temp_table_ctl_out[c] = tctl_of(swcfg_r, 1'(c));
		end
	end

	// ----------------------------------------------------------------
	// Calculation triggers
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			// RULE16: sampled table sources retrigger
			// RULE21: temperature trigger gated
			set_req[c] = have_set_r[c] && (
				(temp_sample_in[c] && tctl_of(swcfg_r, 1'(c)) != bias_ctl_pkg::TCTL_OFF) ||
				(k_sample_in[c] && ksrc_of(swcfg_r, 1'(c)) != bias_ctl_pkg::KSRC_NONE));
			// RULE14: setpoint write starts calculation
			// RULE17: plain pass needs a prior sample
			if (wr_set[c]) begin
				if (ksrc_of(swcfg_r, 1'(c)) == bias_ctl_pkg::KSRC_NONE
					&& tctl_of(swcfg_r, 1'(c)) < 2'h2) begin
					set_req[c] = set_req[c] || seen_r[c];
				end else begin
					set_req[c] = 1'b1;
				end
			end
		end
		issue    = cif.ready && (pend_r != 2'h0);
		issue_ch = !pend_r[0];
		pend_nxt = pend_r;
		if (issue) begin
			pend_nxt[issue_ch] = 1'b0;
		end
		// New request wins over the clear
		pend_nxt = pend_nxt | set_req;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pend_r     <= 2'h0;
			seen_r     <= 2'h0;
			have_set_r <= 2'h0;
			setpt_r    <= '0;
		end else begin
			pend_r     <= pend_nxt;
			seen_r     <= seen_r | temp_sample_in | k_sample_in;
			have_set_r <= have_set_r | wr_set;
			for (int c = 0; c < 2; c++) begin
				if (wr_set[c]) begin
					setpt_r[c] <= cmd_data_in[bias_ctl_pkg::CODE_W-1:0];
				end
			end
		end
	end

	assign cif.start    = issue;
	assign cif.ch       = issue_ch;
	assign cif.setpoint = setpt_r[issue_ch];
	assign cif.k_val    = (ksrc_of(swcfg_r, issue_ch) == bias_ctl_pkg::KSRC_NONE)
		? bias_ctl_pkg::CODE_RST : k_table_value_in[issue_ch];
	assign cif.t_val    = temp_table_value_in[issue_ch];
	assign cif.use_temp = (tctl_of(swcfg_r, issue_ch) != bias_ctl_pkg::TCTL_OFF);

	// ----------------------------------------------------------------
	// DAC input and output registers
	// ----------------------------------------------------------------
	// Host writes land after the calculator so they win a same-cycle clash
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			dac_in_r  <= '0;
			dac_out_r <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				// RULE4: direct load both registers
				// RULE9: channel 1 direct load bit
				if (cif.done && cif.done_ch == 1'(c)) begin
					dac_in_r[c] <= cif.code;
					if (load_of(swcfg_r, 1'(c))) begin
						dac_out_r[c] <= cif.code;
					end
				end
				// RULE5: transfer bit moves input to output
				// RULE12: output waits for transfer
				if (xfer[c]) begin
					dac_out_r[c] <= dac_in_r[c];
				end
				if (wr_in[c] || wr_io[c]) begin
					dac_in_r[c] <= cmd_data_in[bias_ctl_pkg::CODE_W-1:0];
				end
				// RULE13: combined write is immediate
				if (wr_io[c]) begin
					dac_out_r[c] <= cmd_data_in[bias_ctl_pkg::CODE_W-1:0];
				end
			end
		end
	end

	assign ch1_dac_code_out = dac_out_r[0];
	assign ch2_dac_code_out = dac_out_r[1];

	// RULE6: busy pulse on direct load
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= cif.done && load_of(swcfg_r, cif.done_ch);
		end
	end

	assign busy_out = busy_r;

	// ----------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_data_r  <= 16'h0000;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= cmd_valid_in && cmd_byte_in[7];
			// Held between reads, so idle bus noise never shows here
			if (cmd_valid_in && cmd_byte_in[7]) begin
				case (cmd_byte_in)
					bias_ctl_pkg::CMD_SWCFG_RD:   rd_data_r <= {4'h0, swcfg_r};
					bias_ctl_pkg::CMD_HWCFG_RD:   rd_data_r <= {4'h0, hwcfg_r};
					bias_ctl_pkg::CMD_DACOUT1_RD: rd_data_r <= {4'h0, dac_out_r[0]};
					bias_ctl_pkg::CMD_DACOUT2_RD: rd_data_r <= {4'h0, dac_out_r[1]};
					default:                      rd_data_r <= 16'h0000;
				endcase
			end
		end
	end

	assign rd_data_out  = rd_data_r;
	assign rd_valid_out = rd_valid_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	a_conv_ref_sel: assert property (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_HWCFG_WR) // RULE1
		|=> conv_vref_internal_out == $past(cmd_data_in[3]))
		else $error("converter reference select wrong");
	a_dac_ref_sel: assert property (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_HWCFG_WR) // RULE2
		|=> dac_vref_internal_out == $past(cmd_data_in[1]))
		else $error("DAC reference select wrong");
	a_cfg_top_zero: assert property (cmd_valid_in && cmd_byte_in == bias_ctl_pkg::CMD_SWCFG_RD // RULE3
		|=> rd_valid_out && rd_data_out[15:12] == 4'h0)
		else $error("ignored configuration bits read back");
	a_ch2_direct: assert property (cif.done && cif.done_ch && swcfg_r[11] && !xfer[1] && !wr_io[1] // RULE4
		|=> ch2_dac_code_out == $past(cif.code))
		else $error("channel 2 direct load missed");
	a_ch2_hold_out: assert property (cif.done && cif.done_ch && !load_of(swcfg_r, 1'b1) // RULE5
		&& !xfer[1] && !wr_io[1] |=> $stable(ch2_dac_code_out))
		else $error("channel 2 output moved without direct load");
	a_ch1_direct: assert property (cif.done && !cif.done_ch && load_of(swcfg_r, 1'b0) // RULE9
		&& !xfer[0] && !wr_io[0] |=> ch1_dac_code_out == $past(cif.code))
		else $error("channel 1 direct load missed");
	a_ch1_hold_out: assert property (cif.done && !cif.done_ch && !swcfg_r[5] && !xfer[0] && !wr_io[0] // RULE9
		|=> $stable(ch1_dac_code_out))
		else $error("channel 1 output moved without direct load");
	a_busy_pulse: assert property (cif.done && load_of(swcfg_r, cif.done_ch) // RULE6
		|=> busy_out ##1 !busy_out)
		else $error("busy pulse wrong");
	a_input_hold: assert property (wr_in[0] && !xfer[0] && !cif.done |=> $stable(ch1_dac_code_out)) // RULE12
		else $error("input write changed output");
	a_xfer_moves: assert property (xfer[1] && !wr_io[1] // RULE5
		|=> ch2_dac_code_out == $past(dac_in_r[1]))
		else $error("transfer bit did not update output");
	a_combined_write: assert property (wr_io[0] |=> ch1_dac_code_out == $past(cmd_data_in[11:0])) // RULE13
		else $error("combined write not immediate");
	a_setpt_starts: assert property (wr_set[0] && ksrc_of(swcfg_r, 1'b0) != bias_ctl_pkg::KSRC_NONE // RULE14
		|-> ##[1:8] cif.done && !cif.done_ch)
		else $error("setpoint write did not calculate");
	a_pass_blocked: assert property (wr_set[0] && ksrc_of(swcfg_r, 1'b0) == bias_ctl_pkg::KSRC_NONE // RULE17
		&& tctl_of(swcfg_r, 1'b0) < 2'h2 && !seen_r[0] && !temp_sample_in[0] && !pend_r[0]
		|=> !pend_r[0])
		else $error("pass-through case calculated without a sample");
	a_temp_gated: assert property (temp_sample_in[1] && tctl_of(swcfg_r, 1'b1) == bias_ctl_pkg::TCTL_OFF // RULE21
		&& !k_sample_in[1] && !wr_set[1] && !pend_r[1] |=> !pend_r[1])
		else $error("temperature sample triggered while disabled");
	a_ch2_k_field: assert property (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SWCFG_WR) // RULE8
		|=> k_source_sel_out[1] == $past(cmd_data_in[8:6]))
		else $error("channel 2 K source decode wrong");
	a_ch2_t_field: assert property (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SWCFG_WR) // RULE7
		|=> temp_table_ctl_out[1] == $past(cmd_data_in[10:9]))
		else $error("channel 2 temperature control decode wrong");
	a_ch1_k_field: assert property (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SWCFG_WR) // RULE11
		|=> k_source_sel_out[0] == $past(cmd_data_in[2:0]))
		else $error("channel 1 K source decode wrong");
	a_ch1_t_field: assert property (is_wr(cmd_valid_in, cmd_byte_in, bias_ctl_pkg::CMD_SWCFG_WR) // RULE10
		|=> temp_table_ctl_out[0] == $past(cmd_data_in[4:3]))
		else $error("channel 1 temperature control decode wrong");

	c_direct_load: cover property (busy_out);
	c_transfer:    cover property (xfer[0] && !wr_io[0]);
	c_both_pend:   cover property (pend_r == 2'h3);
endmodule

// [testbench/host_model.sv]
// Purpose: Host side of the command port
// Assumes: Commands arrive deframed, one per strobe
// Notes:   Idle bus shows inverted data, never a stale value
`timescale 1ns/1ps
module host_model (
	input  wire logic        clk_in,
	output logic             cmd_valid_out,
	output logic [7:0]       cmd_byte_out,
	output logic [15:0]      cmd_data_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_byte_out  = 8'h00;
		cmd_data_out  = 16'h0000;
	end
	// no converter here, samples come from bench
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] data);
		@(posedge clk_in);
		#1;
		cmd_valid_out = 1'b1;
		cmd_byte_out  = cmd;
		cmd_data_out  = data;
		@(posedge clk_in);
		#1;
		cmd_valid_out = 1'b0;
		cmd_byte_out  = ~cmd;
		cmd_data_out  = ~data;
	endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the DAC code update control
// Assumes: Calculation latency as handed over, fixed
// Notes:   Reads queue expectations, a monitor pops them
`timescale 1ns/1ps
module tb_top;
	logic             clk_in;
	logic             sys_rst_in;
	logic [1:0][11:0] k_tab;
	logic [1:0][11:0] t_tab;
	logic [1:0]       t_smp;
	logic [1:0]       k_smp;
	logic             cmd_valid;
	logic [7:0]       cmd_byte;
	logic [15:0]      cmd_data;
	logic [15:0]      rd_data;
	logic             rd_valid;
	logic             busy;
	logic             conv_int;
	logic             dac_int;
	logic [11:0]      code1;
	logic [11:0]      code2;
	logic [1:0][2:0]  ksel;
	logic [1:0][1:0]  tctl;
	logic [15:0]      exp_q[$];
	logic [15:0]      w;
	int               n_fail = 0;
	int               total_checks = 0;
	int               busy_cnt = 0;

	host_model host_i (.clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte),
		.cmd_data_out(cmd_data));
	dac_code_update_control dac_code_update_control_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.cmd_valid_in(cmd_valid), .cmd_byte_in(cmd_byte), .cmd_data_in(cmd_data),
		.k_table_value_in(k_tab), .temp_table_value_in(t_tab), .temp_sample_in(t_smp),
		.k_sample_in(k_smp), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
		.ch1_dac_code_out(code1), .ch2_dac_code_out(code2), .busy_out(busy),
		.conv_vref_internal_out(conv_int), .dac_vref_internal_out(dac_int),
		.k_source_sel_out(ksel), .temp_table_ctl_out(tctl));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	always @(posedge clk_in) begin
		if (busy === 1'b1) busy_cnt++;
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) chk(rd_data, 16'hDEAD);
			else chk(rd_data, exp_q.pop_front());
		end
	end

	task automatic end_of_test;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
		exp_q.push_back(exp);
		host_i.xfer(cmd, 16'h0000);
	endtask

	// Latency is fixed, so a fixed wait covers done plus busy
	task automatic setpt(input bit ch, input logic [11:0] set, input logic [11:0] exp, input int nb);
		int b0;
		b0 = busy_cnt;
		host_i.xfer(ch ? 8'h45 : 8'h44, {4'hF, set});
		repeat (6) @(posedge clk_in);
		#1;
		chk(16'(busy_cnt - b0), 16'(nb));
		rd(ch ? 8'hC3 : 8'hC2, {4'h0, exp});
	endtask

	// Sample pulses, then time for any calculation they start
	task automatic smp(input logic [1:0] k, input logic [1:0] t);
		k_smp = k;
		t_smp = t;
		@(posedge clk_in);
		#1;
		k_smp = 2'h0;
		t_smp = 2'h0;
		repeat (6) @(posedge clk_in);
		#1;
	endtask

	initial begin
		#1ms;
		n_fail++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		k_tab = '0;
		t_tab = '0;
		t_smp = 2'h0;
		k_smp = 2'h0;
		sys_rst_in = 1'b1;
		void'($urandom(16185));
		repeat (16) @(posedge clk_in);
		#1;
		sys_rst_in = 1'b0;
		chk(code1, 16'h0000);
		repeat (4) begin
			w = 16'($urandom);
			host_i.xfer(8'h3A, w);
			rd(8'hBA, {4'h0, w[11:0]});
			chk(ksel[0], w[2:0]);
			chk(tctl[0], w[4:3]);
			chk(ksel[1], w[8:6]);
			chk(tctl[1], w[10:9]);
		end
		for (int i = 0; i < 16; i++) begin
			host_i.xfer(8'h38, 16'(i));
			@(posedge clk_in);
			#1;
			chk(conv_int, i[3]);
			chk(dac_int, i[1]);
		end
		rd(8'hB8, 16'h000F);
		host_i.xfer(8'h3A, 16'h0000);
		host_i.xfer(8'h40, 16'hF123);
		rd(8'hC2, 16'h0000);
		host_i.xfer(8'h46, 16'h0001);
		rd(8'hC2, 16'h0123);
		host_i.xfer(8'h43, 16'h0ABC);
		rd(8'hC3, 16'h0ABC);
		host_i.xfer(8'h41, 16'h0555);
		host_i.xfer(8'h46, 16'h0002);
		rd(8'hC3, 16'h0555);
		host_i.xfer(8'h3A, 16'h0020);
		setpt(0, 12'h456, 12'h123, 0);
		smp(2'h1, 2'h0);
		setpt(0, 12'h456, 12'h456, 1);
		k_tab[0] = 12'h800;
		t_tab[0] = 12'h400;
		host_i.xfer(8'h3A, 16'h0021);
		setpt(0, 12'h200, 12'h300, 1);
		host_i.xfer(8'h3A, 16'h0029);
		setpt(0, 12'h400, 12'h500, 1);
		t_tab[0] = 12'hC00;
		setpt(0, 12'h400, 12'h300, 1);
		chk(code1, 16'h0300);
		k_tab[0] = 12'h000;
		smp(2'h1, 2'h0);
		rd(8'hC2, 16'h0400);
		k_tab[1] = 12'hFFF;
		host_i.xfer(8'h3A, 16'h0040);
		setpt(1, 12'hFFF, 12'h555, 0);
		host_i.xfer(8'h46, 16'h0002);
		rd(8'hC3, 16'h0FFF);
		chk(code2, 16'h0FFF);
		k_tab[1] = 12'h800;
		host_i.xfer(8'h3A, 16'h0840);
		setpt(1, 12'h100, 12'h180, 1);
		chk(code2, 16'h0180);
		w = 16'(busy_cnt);
		smp(2'h0, 2'h2);
		chk(16'(busy_cnt), w);
		host_i.xfer(8'h42, 16'hA777);
		chk(code1, 16'h0777);
		repeat (4) @(posedge clk_in);
		if (exp_q.size() != 0) n_fail++;
		end_of_test();
	end
endmodule
